// ---- core/bcl_config_latch_top.sv ----
// boot configuration latches with axi4-lite access and reset sampling
`timescale 1ns/1ps
`include "bcl_params.svh"
module bcl_config_latch_top #(
    parameter int unsigned PROG_CYCLES = `BCL_PROG_CYCLES
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             por_n,
    input  wire logic [31:0]      s_axi_awaddr,
    input  wire logic [2:0]       s_axi_awprot,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [31:0]      s_axi_araddr,
    input  wire logic [2:0]       s_axi_arprot,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    output bcl_pkg::bcl_cfg_t     config_out,
    output logic                  config_valid,
    output logic                  prog_busy
);
    // ------------------------------------------------------------------
    // types, helpers
    // ------------------------------------------------------------------
    typedef enum logic {
        PROG_IDLE,
        PROG_WRITE
    } bcl_prog_state_t;

    localparam int unsigned CNT_W = $clog2(PROG_CYCLES + 1);

    // word index of a byte address, or all ones when unmapped
    function automatic logic [2:0] reg_index(input logic [31:0] addr);
        logic [2:0] idx;
        idx = addr[4:2];
        if (addr[31:5] != 27'h0 || addr[1:0] != 2'h0
                || idx > `BCL_IDX_ACTIVE) begin
            reg_index = 3'h7;
        end else begin
            reg_index = idx;
        end
    endfunction : reg_index

    function automatic logic [7:0] factory_byte(input logic [1:0] idx);
        unique case (idx)
            2'h0: factory_byte = `BCL_FACTORY_B0;
            2'h1: factory_byte = `BCL_FACTORY_B1;
            2'h2: factory_byte = `BCL_FACTORY_B2;
            2'h3: factory_byte = `BCL_FACTORY_ECC_B3;
        endcase
    endfunction : factory_byte

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic                  wr_en;
    bcl_pkg::bcl_wr_req_t  wr_req;
    logic                  wr_err;
    logic                  rd_en;
    logic [31:0]           rd_addr;
    bcl_pkg::bcl_rd_rsp_t  rd_rsp;
    logic [2:0]            wr_idx;
    logic [2:0]            rd_idx;

    logic [7:0]            latch_ff [4];
    logic [31:0]           latch_bytes;
    logic [31:0]           active_bytes_ff;
    bcl_pkg::bcl_cfg_t     decoded_cfg;
    logic                  sample_pend_ff;

    bcl_prog_state_t       prog_state_ff;
    logic [1:0]            prog_idx_ff;
    logic [7:0]            prog_data_ff;
    logic [CNT_W-1:0]      prog_cnt_ff;
    logic [15:0]           write_count_ff;
    logic                  refused_ff;
    logic                  skipped_ff;
    logic                  prog_start;
    logic                  prog_bad_start;
    logic                  prog_cmd;
    logic                  prog_done;
    logic                  prog_same;
    logic                  status_wr;

    // ------------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------------
    bcl_axil_slave u_slave (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_req        (wr_req),
        .wr_err        (wr_err),
        .rd_en         (rd_en),
        .rd_addr       (rd_addr),
        .rd_rsp        (rd_rsp)
    );

    assign wr_idx = reg_index(wr_req.addr);
    assign rd_idx = reg_index(rd_addr);
    assign wr_err = (wr_idx == 3'h7);

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    // a command needs both the index and the data lane
    assign prog_cmd = wr_en && (wr_idx == `BCL_IDX_PROG)
                      && (wr_req.strb[1:0] == 2'h3);
    assign prog_start = prog_cmd && (prog_state_ff == PROG_IDLE);
    assign prog_bad_start = prog_cmd && (prog_state_ff != PROG_IDLE);

    assign status_wr = wr_en && (wr_idx == `BCL_IDX_STATUS)
                       && wr_req.strb[0];
    assign prog_done = (prog_state_ff == PROG_WRITE)
                       && (prog_cnt_ff == CNT_W'(1));
    assign prog_same = (latch_ff[prog_idx_ff] == prog_data_ff);

    // ------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------
    always_comb begin
        rd_rsp = '0;
        unique case (rd_idx)
            `BCL_IDX_DRIVE_LOW:   rd_rsp.data = {24'h0, latch_ff[0]};
            `BCL_IDX_DRIVE_HIGH:  rd_rsp.data = {24'h0, latch_ff[1]};
            `BCL_IDX_RESET_DEBUG: rd_rsp.data = {24'h0, latch_ff[2]};
            `BCL_IDX_BOOT_CLOCK:  rd_rsp.data = {24'h0, latch_ff[3]};
            `BCL_IDX_PROG: begin
                rd_rsp.data[`BCL_PROG_IDX_LSB +: 2]  = prog_idx_ff;
                rd_rsp.data[`BCL_PROG_DATA_LSB +: 8] = prog_data_ff;
            end
            `BCL_IDX_STATUS: begin
                rd_rsp.data[`BCL_ST_BUSY_BIT]    = prog_busy;
                rd_rsp.data[`BCL_ST_REFUSED_BIT] = refused_ff;
                rd_rsp.data[`BCL_ST_SKIPPED_BIT] = skipped_ff;
                rd_rsp.data[`BCL_ST_COUNT_LSB +: 16] = write_count_ff;
            end
            `BCL_IDX_ACTIVE:      rd_rsp.data = active_bytes_ff;
            default:              rd_rsp.err  = 1'b1;
        endcase
    end

    // ------------------------------------------------------------------
    // latch store, loaded with factory values only at power-on
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            for (int i = 0; i < 4; i++) begin
                latch_ff[i] <= factory_byte(2'(i)); // see R01
            end
        end else if (aresetn && prog_done && !prog_same) begin
            latch_ff[prog_idx_ff] <= prog_data_ff; // see R02
        end
    end

    // wear counter, survives device reset
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            write_count_ff <= 16'h0;
        end else if (aresetn && prog_done && !prog_same
                     && write_count_ff != 16'hffff) begin
            write_count_ff <= write_count_ff + 16'h1; // see R10
        end
    end

    assign latch_bytes = {latch_ff[3], latch_ff[2], latch_ff[1], latch_ff[0]};

    // ------------------------------------------------------------------
    // programming sequence
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_state_ff <= PROG_IDLE;
            prog_cnt_ff   <= '0;
            prog_busy     <= 1'b0;
        end else begin
            unique case (prog_state_ff)
                PROG_IDLE: begin
                    if (prog_start) begin
                        prog_state_ff <= PROG_WRITE;
                        prog_cnt_ff   <= CNT_W'(PROG_CYCLES);
                        prog_busy     <= 1'b1;
                    end
                end
                PROG_WRITE: begin
                    prog_cnt_ff <= prog_cnt_ff - CNT_W'(1);
                    if (prog_done) begin
                        prog_state_ff <= PROG_IDLE;
                        prog_busy     <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_idx_ff  <= 2'h0;
            prog_data_ff <= 8'h0;
        end else if (prog_start) begin
            prog_idx_ff  <= wr_req.data[`BCL_PROG_IDX_LSB +: 2];
            prog_data_ff <= wr_req.data[`BCL_PROG_DATA_LSB +: 8];
        end
    end

    // sticky flags: write one clears, a new event wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refused_ff <= 1'b0;
            skipped_ff <= 1'b0;
        end else begin
            if (prog_bad_start) begin
                refused_ff <= 1'b1;
            end else if (status_wr
                         && wr_req.data[`BCL_ST_REFUSED_BIT]) begin
                refused_ff <= 1'b0;
            end
            if (prog_done && prog_same) begin
                skipped_ff <= 1'b1; // see R10
            end else if (status_wr
                         && wr_req.data[`BCL_ST_SKIPPED_BIT]) begin
                skipped_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // reset sampling of the applied configuration
    // ------------------------------------------------------------------
    bcl_field_decode u_decode (
        .latch_bytes (latch_bytes),
        .cfg         (decoded_cfg)
    );

    // factory values in reset, sampled at the first edge after
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_pend_ff  <= 1'b1;
            config_valid    <= 1'b0;
            active_bytes_ff <= {`BCL_FACTORY_ECC_B3, `BCL_FACTORY_B2,
                                `BCL_FACTORY_B1, `BCL_FACTORY_B0};
        end else if (sample_pend_ff) begin
            sample_pend_ff  <= 1'b0;
            config_valid    <= 1'b1;
            active_bytes_ff <= latch_bytes; // see R11
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_out <= '0;
            config_out.debug_access_enable     <= 1'b1;
            config_out.boot_imo_mhz            <= `BCL_BOOT_MHZ_SLOW;
            config_out.debug_port_select       <= bcl_pkg::BCL_DBG_JTAG4;
            config_out.jtag4_enable            <= 1'b1;
            config_out.flash_correction_enable <= 1'b1;
        end else if (sample_pend_ff) begin
            config_out <= decoded_cfg; // see R01
        end
    end
endmodule : bcl_config_latch_top

// ---- core/bcl_params.svh ----
// constants of the boot configuration latch block
// Summary of operation
// R01: four latch bytes are kept and applied at every reset.
// R02: bytes 0-1 hold eight port fields; byte 2 reset select, debug, port 8.
// R03: port field 00 analog hi-z, 01 digital hi-z, 10 pull-up, 11 pull-down.
// R04: reset select 0 keeps the shared pin as I/O, 1 makes it a reset input.
// R05: debug enable 0 blocks debug access, 1 permits it.
// R06: boot speed 0 runs the boot oscillator at 12 MHz, 1 at 48 MHz.
// R07: debug port 00 five-wire JTAG, 01 four-wire JTAG, 10 SWD, 11 none.
// R08: correction enable 1 keeps extra flash for check bytes, 0 frees it.
// R09: a four-bit field of the last byte selects the clock phase delay.
// R10: the latches wear out, so reprogramming should be rare.
// R11: fields are sampled once as reset ends and held until the next reset.
`ifndef BCL_PARAMS_SVH
`define BCL_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------------
`define BCL_IDX_DRIVE_LOW   3'h0
`define BCL_IDX_DRIVE_HIGH  3'h1
`define BCL_IDX_RESET_DEBUG 3'h2
`define BCL_IDX_BOOT_CLOCK  3'h3
`define BCL_IDX_PROG        3'h4
`define BCL_IDX_STATUS      3'h5
`define BCL_IDX_ACTIVE      3'h6

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BCL_EXTERNAL_RESET_BIT        7
`define BCL_DEBUG_ACCESS_ENABLE_BIT       6
`define BCL_PORT8_LSB       4
`define BCL_SPEED_BIT       0
`define BCL_DPS_LSB         1
`define BCL_ECC_BIT         3
`define BCL_PHS_LSB         4
`define BCL_PROG_IDX_LSB    0
`define BCL_PROG_DATA_LSB   8
`define BCL_ST_BUSY_BIT     0
`define BCL_ST_REFUSED_BIT  1
`define BCL_ST_SKIPPED_BIT  2
`define BCL_ST_COUNT_LSB    16

// ----------------------------------------------------------------------
// factory values and timing
// ----------------------------------------------------------------------
`define BCL_FACTORY_B0      8'h00
`define BCL_FACTORY_B1      8'h00
`define BCL_FACTORY_B2      8'h40
`define BCL_FACTORY_ECC_B3  8'h0a
`define BCL_BOOT_MHZ_SLOW   7'h0c
`define BCL_BOOT_MHZ_FAST   7'h30
`define BCL_PROG_CYCLES     64

`endif

// ---- core/bcl_pkg.sv ----
// types of the boot configuration latch block
package bcl_pkg;

    typedef enum logic [1:0] {
        BCL_DRV_HIZ_ANALOG  = 2'h0,
        BCL_DRV_HIZ_DIGITAL = 2'h1,
        BCL_DRV_PULL_UP     = 2'h2,
        BCL_DRV_PULL_DOWN   = 2'h3
    } bcl_drive_mode_t;

    typedef enum logic [1:0] {
        BCL_DBG_JTAG5 = 2'h0,
        BCL_DBG_JTAG4 = 2'h1,
        BCL_DBG_SWD   = 2'h2,
        BCL_DBG_NONE  = 2'h3
    } bcl_dbg_port_t;

    typedef struct packed {
        bcl_drive_mode_t [8:0] port_reset_drive_mode;
        logic                  ext_reset_pin_select;
        logic                  debug_access_enable;
        logic                  boot_clock_speed;
        logic [6:0]            boot_imo_mhz;
        bcl_dbg_port_t         debug_port_select;
        logic                  jtag5_enable;
        logic                  jtag4_enable;
        logic                  swd_enable;
        logic                  flash_correction_enable;
        logic [3:0]            digital_clock_phase_delay;
    } bcl_cfg_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } bcl_wr_req_t;

    typedef struct packed {
        logic [31:0] data;
        logic        err;
    } bcl_rd_rsp_t;

endpackage : bcl_pkg

// ---- core/bcl_field_decode.sv ----
// decode of the four latch bytes into configuration fields
`timescale 1ns/1ps
`include "bcl_params.svh"
module bcl_field_decode (
    input  wire logic [31:0]      latch_bytes,
    output bcl_pkg::bcl_cfg_t     cfg
);
    logic [7:0] b2;
    logic [7:0] b3;

    assign b2 = latch_bytes[23:16];
    assign b3 = latch_bytes[31:24];

    always_comb begin
        cfg = '0;
        for (int i = 0; i < 8; i++) begin
            cfg.port_reset_drive_mode[i] =
                bcl_pkg::bcl_drive_mode_t'(latch_bytes[2*i +: 2]); // see R03
        end
        cfg.port_reset_drive_mode[8] =
            bcl_pkg::bcl_drive_mode_t'(b2[`BCL_PORT8_LSB +: 2]); // see R02
        cfg.ext_reset_pin_select = b2[`BCL_EXTERNAL_RESET_BIT]; // see R04
        cfg.debug_access_enable  = b2[`BCL_DEBUG_ACCESS_ENABLE_BIT]; // see R05
        cfg.boot_clock_speed     = b3[`BCL_SPEED_BIT];
        cfg.boot_imo_mhz = b3[`BCL_SPEED_BIT] ? `BCL_BOOT_MHZ_FAST
                                              : `BCL_BOOT_MHZ_SLOW; // see R06
        cfg.debug_port_select =
            bcl_pkg::bcl_dbg_port_t'(b3[`BCL_DPS_LSB +: 2]); // see R07
        // no port opens while debug access is blocked
        cfg.jtag5_enable = b2[`BCL_DEBUG_ACCESS_ENABLE_BIT]
            && (cfg.debug_port_select == bcl_pkg::BCL_DBG_JTAG5); // see R05
        cfg.jtag4_enable = b2[`BCL_DEBUG_ACCESS_ENABLE_BIT]
            && (cfg.debug_port_select == bcl_pkg::BCL_DBG_JTAG4); // see R07
        cfg.swd_enable   = b2[`BCL_DEBUG_ACCESS_ENABLE_BIT]
            && (cfg.debug_port_select == bcl_pkg::BCL_DBG_SWD); // see R07
        cfg.flash_correction_enable = b3[`BCL_ECC_BIT]; // see R08
        cfg.digital_clock_phase_delay = b3[`BCL_PHS_LSB +: 4]; // see R09
    end
endmodule : bcl_field_decode

// ---- core/bcl_axil_slave.sv ----
// axi4-lite slave front end with one write and one read in flight
`timescale 1ns/1ps
module bcl_axil_slave (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [31:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [31:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic                      wr_en,
    output bcl_pkg::bcl_wr_req_t      wr_req,
    input  wire logic                 wr_err,
    output logic                      rd_en,
    output logic [31:0]               rd_addr,
    input  wire bcl_pkg::bcl_rd_rsp_t rd_rsp
);
    logic aw_held_ff;
    logic w_held_ff;
    logic nxt_aw_held;
    logic nxt_w_held;
    logic nxt_bvalid;

    assign wr_en   = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign rd_en   = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;

    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_w_held  = w_held_ff;
        nxt_bvalid  = s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_held = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_held = 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (wr_en) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            aw_held_ff    <= nxt_aw_held;
            w_held_ff     <= nxt_w_held;
            s_axi_bvalid  <= nxt_bvalid;
            s_axi_awready <= !nxt_aw_held && !nxt_bvalid && !wr_en;
            s_axi_wready  <= !nxt_w_held && !nxt_bvalid && !wr_en;
            if (wr_en) begin
                s_axi_bresp <= wr_err ? 2'h2 : 2'h0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_req <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_req.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_req.data <= s_axi_wdata;
                wr_req.strb <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else if (rd_en) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_rsp.data;
            s_axi_rresp   <= rd_rsp.err ? 2'h2 : 2'h0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule : bcl_axil_slave

// ---- tb/bcl_config_latch_properties.sv ----
// concurrent checks on the configuration latch top
`timescale 1ns/1ps
module bcl_checker #(
    parameter int unsigned PROG_CYCLES = 64
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire bcl_pkg::bcl_cfg_t config_out,
    input wire logic              config_valid,
    input wire logic              prog_busy
);
    // ------------
    // helpers and properties
    // ------------
    int unsigned busy_ff;
    logic [2:0]  dbg;
    assign dbg = {config_out.jtag5_enable, config_out.jtag4_enable,
                  config_out.swd_enable};
    always_ff @(posedge aclk) busy_ff <= prog_busy ? busy_ff + 32'h1 : 32'h0;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd_stall;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    a_valid_rise: assert property ($rose(aresetn) |=> config_valid)
        else $error("config not valid");
    a_cfg_held: assert property (config_valid && $past(config_valid)
        |-> $stable(config_out)) else $error("config changed");
    a_imo_speed: assert property (config_valid |->
        config_out.boot_imo_mhz == (config_out.boot_clock_speed ? 7'h30
        : 7'h0c)) else $error("boot speed wrong");
    a_dbg_block: assert property (config_valid &&
        !config_out.debug_access_enable |-> dbg == 3'h0)
        else $error("debug not blocked");
    a_dbg_port_map: assert property (config_valid &&
        config_out.debug_access_enable |->
        dbg == (3'h4 >> config_out.debug_port_select))
        else $error("debug port wrong");
    a_rdata_hold: assert property (s_rd_stall |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp lost");
    a_prog_len: assert property ($fell(prog_busy) |->
        busy_ff == PROG_CYCLES) else $error("write length wrong");
endmodule : bcl_checker

bind bcl_config_latch_top bcl_checker #(.PROG_CYCLES(PROG_CYCLES)) u_bcl_chk (
    .aclk, .aresetn, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .config_out,
    .config_valid, .prog_busy);

// ---- tb/bcl_config_latch_top_tb.sv ----
// self-checking bench for the configuration latch top
`timescale 1ns/1ps
module bcl_config_latch_top_tb;
    // ------------
    // signals, instance and bus tasks
    // ------------
    logic              aclk, aresetn, por_n, prog_busy, config_valid;
    logic [31:0]       s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_rready, s_axi_awready;
    logic              s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    bcl_pkg::bcl_cfg_t c;
    int                err_count, samples_checked;
    logic [7:0]        fac [4] = '{8'h00, 8'h00, 8'h40, 8'h0a};

    bcl_config_latch_top #(.PROG_CYCLES(4)) u_bcl_config_latch_top (
        .aclk, .aresetn, .por_n, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .config_out(c), .config_valid, .prog_busy);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bit ta = 0, tw = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            ta = ta | s_axi_awready;
            tw = tw | s_axi_wready;
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
        end
        s_axi_bready <= 1'h1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : rd

    task automatic rst(input logic p);
        aresetn <= 1'h0;
        por_n <= p;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        por_n <= 1'h1;
        repeat (2) @(posedge aclk);
    endtask : rst

    // program one byte, wait, read it back
    task automatic prog(input logic [1:0] i, input logic [7:0] d);
        logic [31:0] q;
        logic [1:0]  r;
        wr(32'h10, {16'h0, d, 6'h0, i});
        while (prog_busy) @(posedge aclk);
        rd({28'h0, i, 2'h0}, q, r);
        chk(q, {24'h0, d});
    endtask : prog

    function automatic logic [31:0] sig();
        return {c.ext_reset_pin_select, c.debug_access_enable,
                c.debug_port_select, c.jtag5_enable, c.jtag4_enable,
                c.swd_enable, c.flash_correction_enable,
                c.digital_clock_phase_delay, c.boot_clock_speed,
                c.boot_imo_mhz};
    endfunction : sig

    function automatic logic [31:0] want(logic x, logic e, logic [1:0] p,
                                         logic f, logic [3:0] h, logic s);
        return {x, e, p, e ? 3'h4 >> p : 3'h0, f, h, s, s ? 7'h30 : 7'h0c};
    endfunction : want

    task automatic tally_and_finish();
        $display("checked %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic t_factory();
        logic [31:0] q;
        logic [1:0]  r;
        for (int i = 0; i < 4; i++) begin
            rd(32'(i * 4), q, r);
            chk(q, {24'h0, fac[i]});
        end
        chk(32'(c.port_reset_drive_mode), 32'h0);
        chk(sig(), want(1'h0, 1'h1, 2'h1, 1'h1, 4'h0, 1'h0));
        chk({31'h0, config_valid}, 32'h1);
        rd(32'h1c, q, r);
        chk({30'h0, r}, 32'h2);
    endtask : t_factory

    task automatic t_program();
        prog(2'h0, 8'he4);
        prog(2'h1, 8'h1b);
        prog(2'h2, 8'hb0);
        prog(2'h3, 8'hf7);
        chk(sig(), want(1'h0, 1'h1, 2'h1, 1'h1, 4'h0, 1'h0));
        rst(1'h1);
        chk(32'(c.port_reset_drive_mode), {14'h0, 18'h31be4});
        chk(sig(), want(1'h1, 1'h0, 2'h3, 1'h0, 4'hf, 1'h1));
    endtask : t_program

    task automatic t_dps();
        prog(2'h2, 8'h40);
        for (int d = 0; d < 4; d++) begin
            prog(2'h3, {4'h0, 1'h1, 2'(d), 1'h0});
            rst(1'h1);
            chk(sig(), want(1'h0, 1'h1, 2'(d), 1'h1, 4'h0, 1'h0));
        end
    endtask : t_dps

    initial begin
        aclk = 1'h0;
        forever #2.5 aclk = ~aclk;
    end

    initial begin
        {aresetn, por_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_araddr = '0;
        rst(1'h0);
        t_factory();
        t_program();
        t_dps();
        tally_and_finish();
    end

    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end
endmodule : bcl_config_latch_top_tb
